//--- src/gbsp_top.sv
// Boot strap pin and general pin logic.
// Assumes the chip reset pin arrives asynchronously and is sampled here.
// Behaviour
// - Pull-up on while chip reset asserted.
// - Pull-up off a few cycles after release.
// - Sample strap level at reset release.
// - Sampled strap held in status bit.
// - After release, strap pin is GPIO, receive or bank line.
// - Strap low selects external program memory.
// - Strap high selects internal ROM.
// - Bank line selects upper half of memory.
// - Lines six to eleven: input, edge, output.
// - Line twelve has no edge interrupt option.
// - Lines eight, ten, eleven switch card supply.
`timescale 1ns/1ps
module gbsp_top #(
  parameter int HOLD_CYC = gbsp_pkg::PULLUP_HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_active_low_chip_reset_n,
  input wire logic i_strap_pin,
  input wire gbsp_pkg::gbsp_strap_use_type i_strap_use,
  input wire logic i_strap_gpio_out,
  input wire logic i_strap_gpio_oe,
  input wire logic i_bank_upper,
  input wire logic [6:0] i_gen_pin,
  input wire logic [13:0] i_gen_mode,
  input wire logic [6:0] i_gen_out,
  input wire logic [6:0] i_edge_rise,
  input wire logic [6:0] i_edge_clear,
  output logic o_strap_pullup_en,
  output logic o_strap_out,
  output logic o_strap_oe,
  output logic o_strap_gpio_in,
  output logic o_serial_rx,
  output logic o_boot_memory_select_strap,
  output logic o_external_fetch,
  output logic o_in_chip_reset,
  output logic [6:0] o_gen_out,
  output logic [6:0] o_gen_oe,
  output logic [6:0] o_gen_in,
  output logic [6:0] o_edge_flag,
  output logic [2:0] o_card_supply_switch
);
  logic rst_n_s;
  logic strap_s;
  logic [6:0] gen_s;
  logic rst_n_prev_q;
  logic [6:0] gen_prev_q;
  logic [7:0] hold_q;
  logic release_w;
  gbsp_pkg::gbsp_drive_type strap_drive_d;

  typedef enum logic [2:0] {
    GBSP_BOOT_HELD = 3'h1,
    GBSP_BOOT_SETTLE = 3'h2,
    GBSP_BOOT_RUN = 3'h4
  } gbsp_boot_state_type;

  gbsp_boot_state_type boot_state_q;

  gbsp_sync #(.WIDTH(9)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_active_low_chip_reset_n, i_strap_pin, i_gen_pin}),
    .o_sync({rst_n_s, strap_s, gen_s})
  );
  assign release_w = rst_n_s & ~rst_n_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rst_n_prev_q <= 1'b0;
      o_in_chip_reset <= 1'b1;
    end else begin
      rst_n_prev_q <= rst_n_s;
      o_in_chip_reset <= ~rst_n_s;
    end
  end

  // Pull-up stays on a short while after release so the strap level is settled when sampled.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_state_q <= GBSP_BOOT_HELD;
      hold_q <= '0;
      o_strap_pullup_en <= 1'b1;
    end else if (!rst_n_s) begin
      boot_state_q <= GBSP_BOOT_HELD;
      hold_q <= 8'(HOLD_CYC);
      o_strap_pullup_en <= 1'b1;
    end else begin
      case (boot_state_q)
        GBSP_BOOT_HELD, GBSP_BOOT_SETTLE: begin
          if (hold_q != 8'h00) begin
            boot_state_q <= GBSP_BOOT_SETTLE;
            hold_q <= hold_q - 8'h01;
            o_strap_pullup_en <= 1'b1;
          end else begin
            boot_state_q <= GBSP_BOOT_RUN;
            o_strap_pullup_en <= 1'b0;
          end
        end
        GBSP_BOOT_RUN: begin
          o_strap_pullup_en <= 1'b0;
        end
        default: begin
          boot_state_q <= GBSP_BOOT_HELD;
          o_strap_pullup_en <= 1'b1;
        end
      endcase
    end
  end

  // Only the release edge and i_rst write the bit, so software cannot alter it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_boot_memory_select_strap <= gbsp_pkg::STRAP_RESET;
      o_external_fetch <= 1'b0;
    end else if (release_w) begin
      o_boot_memory_select_strap <= strap_s;
      o_external_fetch <= ~strap_s;
    end
  end

  always_comb begin
    strap_drive_d = '0;
    case (i_strap_use)
      gbsp_pkg::GBSP_STRAP_GPIO: begin
        strap_drive_d.out = i_strap_gpio_out;
        strap_drive_d.oe = i_strap_gpio_oe;
      end
      gbsp_pkg::GBSP_STRAP_BANK: begin
        strap_drive_d.out = i_bank_upper;
        strap_drive_d.oe = 1'b1;
      end
      default: begin
        strap_drive_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !rst_n_s) begin
      o_strap_out <= 1'b0;
      o_strap_oe <= 1'b0;
      o_strap_gpio_in <= 1'b0;
      o_serial_rx <= 1'b1;
    end else begin
      o_strap_gpio_in <= strap_s;
      o_serial_rx <= (i_strap_use == gbsp_pkg::GBSP_STRAP_RX) ? strap_s : 1'b1;
      o_strap_out <= strap_drive_d.out;
      o_strap_oe <= strap_drive_d.oe;
    end
  end

  genvar g;
  generate
    for (g = 0; g < gbsp_pkg::NUM_GEN; g++) begin : gen_line
      gbsp_pkg::gbsp_mode_type mode_w;
      logic can_edge;
      logic can_supply;
      gbsp_pkg::gbsp_drive_type line_drive_d;
      assign mode_w = gbsp_pkg::gbsp_mode_type'(i_gen_mode[2*g+1:2*g]);
      assign can_edge = gbsp_pkg::EDGE_CAPABLE[g];
      assign can_supply = gbsp_pkg::SUPPLY_CAPABLE[g];

      always_ff @(posedge i_clk) begin
        if (i_rst || !rst_n_s) begin
          gen_prev_q[g] <= 1'b0;
          o_gen_in[g] <= 1'b0;
        end else begin
          gen_prev_q[g] <= gen_s[g];
          o_gen_in[g] <= gen_s[g];
        end
      end

      // A new edge beats a clear in the same cycle.
      // The release cycle is skipped, since the line history is stale then.
      always_ff @(posedge i_clk) begin
        if (i_rst || !rst_n_s) begin
          o_edge_flag[g] <= 1'b0;
        end else if (rst_n_prev_q && can_edge && mode_w == gbsp_pkg::GBSP_MODE_EDGE &&
                     (gen_s[g] != gen_prev_q[g]) &&
                     (gen_s[g] == i_edge_rise[g])) begin
          o_edge_flag[g] <= 1'b1;
        end else if (i_edge_clear[g]) begin
          o_edge_flag[g] <= 1'b0;
        end
      end

      always_comb begin
        line_drive_d = '0;
        case (mode_w)
          gbsp_pkg::GBSP_MODE_OUT: begin
            line_drive_d.out = i_gen_out[g];
            line_drive_d.oe = 1'b1;
          end
          gbsp_pkg::GBSP_MODE_SUPPLY: begin
            line_drive_d.out = can_supply;
            line_drive_d.oe = can_supply;
          end
          default: begin
            line_drive_d = '0;
          end
        endcase
      end

      always_ff @(posedge i_clk) begin
        if (i_rst || !rst_n_s) begin
          o_gen_out[g] <= 1'b0;
          o_gen_oe[g] <= 1'b0;
        end else begin
          o_gen_out[g] <= line_drive_d.out;
          o_gen_oe[g] <= line_drive_d.oe;
        end
      end
    end
  endgenerate

  // Card supply switches follow lines eight, ten and eleven in supply mode.
  always_ff @(posedge i_clk) begin
    if (i_rst || !rst_n_s) begin
      o_card_supply_switch <= '0;
    end else begin
      o_card_supply_switch[0] <= (i_gen_mode[5:4] == 2'h3);
      o_card_supply_switch[1] <= (i_gen_mode[9:8] == 2'h3);
      o_card_supply_switch[2] <= (i_gen_mode[11:10] == 2'h3);
    end
  end
endmodule : gbsp_top

//--- src/gbsp_pkg.sv
// Package for the boot strap and general pin block.
// Assumes a 100 MHz system clock and one synchronous active-high reset.
package gbsp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULLUP_HOLD_NS = 50;
  localparam int PULLUP_HOLD_CYC = (PULLUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_GEN = 7;
  localparam logic STRAP_RESET = 1'b1;
  localparam logic [6:0] EDGE_CAPABLE = 7'h3f;
  localparam logic [6:0] SUPPLY_CAPABLE = 7'h34;

  typedef enum logic [1:0] {
    GBSP_MODE_IN = 2'h0,
    GBSP_MODE_EDGE = 2'h1,
    GBSP_MODE_OUT = 2'h2,
    GBSP_MODE_SUPPLY = 2'h3
  } gbsp_mode_type;

  typedef enum logic [1:0] {
    GBSP_STRAP_GPIO = 2'h0,
    GBSP_STRAP_RX = 2'h1,
    GBSP_STRAP_BANK = 2'h2
  } gbsp_strap_use_type;

  typedef struct packed {
    logic out;
    logic oe;
  } gbsp_drive_type;
endpackage : gbsp_pkg

//--- src/gbsp_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
module gbsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_sync <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two settled stages agree.
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_sync[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : gbsp_sync

//--- sim/gbsp_monitor.sv
// Checker for the strap pin and general lines.
// Bound into gbsp_top; sees its ports only.
`timescale 1ns/1ps
module gbsp_monitor #(
  parameter int HOLD_CYC = 5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire gbsp_pkg::gbsp_strap_use_type i_strap_use,
  input wire logic i_bank_upper,
  input wire logic [13:0] i_gen_mode,
  input wire logic [6:0] i_gen_out,
  input wire logic o_strap_pullup_en,
  input wire logic o_strap_out,
  input wire logic o_strap_oe,
  input wire logic o_boot_memory_select_strap,
  input wire logic o_external_fetch,
  input wire logic o_in_chip_reset,
  input wire logic [6:0] o_gen_out,
  input wire logic [6:0] o_gen_oe,
  input wire logic [6:0] o_edge_flag,
  input wire logic [2:0] o_card_supply_switch
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_pullup_in_reset: assert property (o_in_chip_reset |-> o_strap_pullup_en)
    else $error("pull-up off in reset");
  chk_pullup_late_off: assert property ($fell(o_in_chip_reset) |->
    o_strap_pullup_en [*2] ##[1:HOLD_CYC] !o_strap_pullup_en) else $error("pull-up release");
  chk_fetch_matches: assert property (o_external_fetch == !o_boot_memory_select_strap)
    else $error("fetch and select differ");
  chk_select_holds: assert property (!o_in_chip_reset && !$past(o_in_chip_reset, 3) |->
    $stable(o_boot_memory_select_strap)) else $error("select moved");
  chk_twelve_no_edge: assert property (!o_edge_flag[6]) else $error("line twelve flag");
  chk_supply_needs_mode: assert property (o_card_supply_switch[0] |->
    $past(i_gen_mode[5:4]) == 2'h3) else $error("supply without mode");
  chk_line_out_drive: assert property ($past(i_gen_mode[1:0]) == 2'h2 && !o_in_chip_reset
    && !$past(o_in_chip_reset) |-> o_gen_oe[0] && o_gen_out[0] == $past(i_gen_out[0]))
    else $error("line six drive");
  chk_bank_line: assert property ($past(i_strap_use) == gbsp_pkg::GBSP_STRAP_BANK
    && !o_in_chip_reset && !$past(o_in_chip_reset) |-> o_strap_oe
    && o_strap_out == $past(i_bank_upper)) else $error("bank line");
  cov_release: cover property ($fell(o_in_chip_reset));
  cov_external: cover property (o_external_fetch);
  cov_supply: cover property (o_card_supply_switch == 3'h7);
endmodule : gbsp_monitor
bind gbsp_top gbsp_monitor #(.HOLD_CYC(HOLD_CYC)) i_gbsp_monitor (.*);

//--- sim/gbsp_board.sv
// Board model of the strap pin.
// A floating pin shows the inverse of its last level, so no stale value passes.
`timescale 1ns/1ps
module gbsp_board (
  input wire logic i_clk,
  input wire logic i_pull_low,
  input wire logic i_pullup_en,
  input wire logic i_out,
  input wire logic i_oe,
  output logic o_pin
);
  logic last_q = 1'h0;
  always_comb o_pin = i_oe ? i_out : i_pull_low ? 1'h0 : i_pullup_en ? 1'h1 : ~last_q;
  always_ff @(posedge i_clk) last_q <= o_pin;
endmodule : gbsp_board

//--- sim/gbsp_top_test.sv
// Bench for the strap pin and general lines.
// Inputs change at the rising edge; outputs are read 1 ns later.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module gbsp_top_test;
  logic i_clk = 1'h0, i_rst = 1'h1, i_active_low_chip_reset_n = 1'h1, pull_low = 1'h0;
  logic i_strap_gpio_out = 1'h0, i_strap_gpio_oe = 1'h0, i_bank_upper = 1'h0;
  gbsp_pkg::gbsp_strap_use_type i_strap_use = gbsp_pkg::GBSP_STRAP_GPIO;
  logic [6:0] i_gen_pin = 7'h00, i_gen_out = 7'h00, i_edge_rise = 7'h00, i_edge_clear = 7'h00;
  logic [13:0] i_gen_mode = 14'h0000;
  logic i_strap_pin, o_strap_pullup_en, o_strap_out, o_strap_oe, o_strap_gpio_in, o_serial_rx;
  logic o_boot_memory_select_strap, o_external_fetch, o_in_chip_reset;
  logic [6:0] o_gen_out, o_gen_oe, o_gen_in, o_edge_flag;
  logic [2:0] o_card_supply_switch;
  int mismatches = 0, comparisons = 0;
  always #5 i_clk = ~i_clk;
  gbsp_board i_gbsp_board (.i_clk, .i_pull_low(pull_low), .i_pullup_en(o_strap_pullup_en),
    .i_out(o_strap_out), .i_oe(o_strap_oe), .o_pin(i_strap_pin));
  gbsp_top i_gbsp_top (.*);
  task automatic cyc(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic boot(logic low, logic exp);
    @(posedge i_clk);
    pull_low <= low;
    i_active_low_chip_reset_n <= 1'h0;
    cyc(gbsp_pkg::RESET_MIN_CYC + 2);
    `CHK(o_strap_pullup_en, 1'h1)
    @(posedge i_clk);
    i_active_low_chip_reset_n <= 1'h1;
    cyc(6);
    `CHK({o_strap_pullup_en, o_boot_memory_select_strap, o_external_fetch}, {1'h1, exp, ~exp})
    cyc(8);
    `CHK(o_strap_pullup_en, 1'h0)
  endtask : boot
  task automatic su(gbsp_pkg::gbsp_strap_use_type u, logic oe, logic v);
    @(posedge i_clk);
    i_strap_use <= u;
    i_strap_gpio_oe <= oe;
    i_strap_gpio_out <= v;
    i_bank_upper <= v;
    cyc(6);
  endtask : su
  task automatic gl(logic [13:0] m, logic [6:0] p, logic [6:0] r, logic [6:0] c);
    @(posedge i_clk);
    i_gen_mode <= m;
    i_gen_out <= 7'h55;
    i_gen_pin <= p;
    i_edge_rise <= r;
    i_edge_clear <= c;
    cyc(6);
  endtask : gl
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #20us;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    boot(1'h1, 1'h0);
    $display("external boot done");
    su(gbsp_pkg::GBSP_STRAP_RX, 1'h0, 1'h0);
    `CHK(o_serial_rx, 1'h0)
    su(gbsp_pkg::GBSP_STRAP_GPIO, 1'h1, 1'h1);
    `CHK({o_strap_oe, o_strap_out, o_strap_gpio_in}, 3'h7)
    `CHK(o_serial_rx, 1'h1)
    su(gbsp_pkg::GBSP_STRAP_BANK, 1'h0, 1'h1);
    `CHK({o_strap_oe, o_strap_out}, 2'h3)
    su(gbsp_pkg::GBSP_STRAP_GPIO, 1'h0, 1'h0);
    pull_low <= 1'h0;
    cyc(20);
    `CHK(o_boot_memory_select_strap, 1'h0)
    $display("strap use done");
    boot(1'h0, 1'h1);
    cyc(20);
    `CHK(o_boot_memory_select_strap, 1'h1)
    $display("internal boot done");
    gl(14'h2aaa, 7'h00, 7'h00, 7'h00);
    `CHK({o_gen_oe, o_gen_out, o_card_supply_switch}, 17'h1fea8)
    gl(14'h0000, 7'h2a, 7'h00, 7'h00);
    `CHK({o_gen_oe, o_gen_in}, 14'h002a)
    gl(14'h1555, 7'h00, 7'h7f, 7'h00);
    gl(14'h1555, 7'h7f, 7'h7f, 7'h00);
    `CHK(o_edge_flag, 7'h3f)
    gl(14'h1555, 7'h7f, 7'h00, 7'h7f);
    `CHK(o_edge_flag, 7'h00)
    gl(14'h1555, 7'h00, 7'h00, 7'h00);
    `CHK(o_edge_flag, 7'h3f)
    gl(14'h3fff, 7'h00, 7'h00, 7'h00);
    `CHK(o_card_supply_switch, 3'h7)
    `CHK({o_gen_oe, o_gen_out}, {gbsp_pkg::SUPPLY_CAPABLE, gbsp_pkg::SUPPLY_CAPABLE})
    $display("general lines done");
    report_and_stop();
  end
endmodule : gbsp_top_test
